// >>> sdr_cfg.svh
// Constants of the synchronous DRAM command and burst block.
//
// Overview of operation
// - Mode set is all command strobes low; address inputs load the mode.
// - Column access is RAS high, CAS low; write enable picks read or write.
// - Device accepts a read or write on every cycle, any open bank.
// - Read command decode; burst length comes from the mode, type bit unused, always sequential.
// - First write word is taken with the command, then one per edge.
// - Interrupting read restarts a full burst; old data runs until latency.
// - Interrupting write continues from the new address for a full burst.
// - Read ends a write burst at once; controller frees the bus early.
// - Burst stop keeps the bank open; reads float after latency, writes stop.
// - Sequential bursts wrap inside blocks of 2, 4 or 8 columns.
// - Read latencies of two and three cycles are supported.
// - Data mask floats read data two cycles later and blocks writes at once.
// - Eleven row bits and eight column bits share the address pins.
`ifndef SDR_CFG_SVH
`define SDR_CFG_SVH
`define SDR_BL_LSB    0
`define SDR_BT_BIT    3
`define SDR_CL_LSB    4
`define SDR_MODE_RST  11'h020
`define SDR_BL_1      3'h0
`define SDR_BL_2      3'h1
`define SDR_BL_4      3'h2
`define SDR_BL_8      3'h3
`define SDR_BL_FULL   3'h7
`define SDR_CL_2      3'h2
`define SDR_REF_NEED  4'h8
`endif

// >>> sdr_pkg.sv
// Types shared by the synchronous DRAM command and burst block.
package sdr_pkg;
  typedef enum logic [3:0] {
    SDR_NOP  = 4'h0,
    SDR_ACT  = 4'h1,
    SDR_RD   = 4'h2,
    SDR_WR   = 4'h3,
    SDR_MRS  = 4'h4,
    SDR_REF  = 4'h5,
    SDR_PRE  = 4'h6,
    SDR_BST  = 4'h7
  } sdr_cmd_t;
endpackage : sdr_pkg

// >>> sdr_device.sv
// Command decoder, burst engine, write buffer and storage of the DRAM device.
`timescale 1ns/10ps
`include "sdr_cfg.svh"

module sdr_fifo #(
  parameter int W     = 38,
  parameter int DEPTH = 32
) (
  input  wire logic         clock,      // System clock.
  input  wire logic         rst,        // Synchronous reset.
  input  wire logic         in_valid,   // Word offered.
  output logic              in_ready,   // Room for a word.
  input  wire logic [W-1:0] in_data,    // Word to store.
  output logic              out_valid,  // Word available.
  input  wire logic         out_ready,  // Drain takes the word.
  output logic [W-1:0]      out_data    // Oldest word.
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("sdr_fifo depth must be a power of two");
  end
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  assign in_ready  = (wp ^ rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp != rp;
  assign out_data  = mem[rp[AW-1:0]];
  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp <= wp + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule : sdr_fifo

module sdr_device #(
  parameter int ROW_W      = 11,
  parameter int COL_W      = 8,
  parameter int DQ_W       = 16,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic             clock,       // System clock, rising edge.
  input  wire logic             rst,         // Power-up reset, active high.
  input  wire logic             cke,         // Clock enable.
  input  wire logic             cs_n,        // Chip select.
  input  wire logic             ras_n,       // Row strobe.
  input  wire logic             cas_n,       // Column strobe.
  input  wire logic             we_n,        // Write enable.
  input  wire logic             ba,          // Bank select.
  input  wire logic [ROW_W-1:0] addr,        // Row or column address.
  input  wire logic [1:0]       dqm,         // Byte masks, upper and lower.
  input  wire logic [DQ_W-1:0]  dq_in,       // Data pins, input side.
  output logic      [DQ_W-1:0]  dq_out,      // Data pins, output side.
  output logic      [1:0]       dq_oe,       // Byte drive enables.
  input  wire logic             drain_hold,  // Stalls the write drain.
  output logic                  fifo_ready,  // Write buffer has room.
  output logic                  init_done    // Mode set and refreshes seen.
);
  localparam int ENT_W = 1 + ROW_W + COL_W + DQ_W + 2;
  localparam int MEM_D = 2 ** (1 + ROW_W + COL_W);
  if (COL_W < 3 || COL_W >= ROW_W || DQ_W != 16) begin : g_chk
    $error("sdr_device widths not supported");
  end

  function automatic sdr_pkg::sdr_cmd_t decode(input logic [3:0] s);
    sdr_pkg::sdr_cmd_t c;
    c = sdr_pkg::SDR_NOP;
    if (!s[3]) begin
      case (s[2:0])
        3'h3: c = sdr_pkg::SDR_ACT;
        3'h5: c = sdr_pkg::SDR_RD;
        3'h4: c = sdr_pkg::SDR_WR;
        3'h0: c = sdr_pkg::SDR_MRS;
        3'h1: c = sdr_pkg::SDR_REF;
        3'h2: c = sdr_pkg::SDR_PRE;
        3'h6: c = sdr_pkg::SDR_BST;
        default: c = sdr_pkg::SDR_NOP;
      endcase
    end
    return c;
  endfunction : decode

  function automatic logic [COL_W-1:0] wrap_mask(input logic [2:0] bl);
    logic [COL_W-1:0] m;
    m = '0;
    case (bl)
      `SDR_BL_2:    m = COL_W'(8'h01);
      `SDR_BL_4:    m = COL_W'(8'h03);
      `SDR_BL_8:    m = COL_W'(8'h07);
      `SDR_BL_FULL: m = '1;
      default:      m = '0;
    endcase
    return m;
  endfunction : wrap_mask

  function automatic logic [COL_W-1:0] next_col(input logic [COL_W-1:0] c,
                                                input logic [2:0]       bl);
    logic [COL_W-1:0] m;
    m = wrap_mask(bl);
    return (c & ~m) | ((c + 1'b1) & m);
  endfunction : next_col

  sdr_pkg::sdr_cmd_t cmd;
  logic [ROW_W-1:0]  mode;
  logic [2:0]        bl;
  logic              cl2;
  logic [1:0]        open;
  logic [ROW_W-1:0]  row [2];
  logic [3:0]        ref_cnt;
  logic              mode_set;
  logic              start_rd;
  logic              start_wr;
  logic              bst_act;
  logic              bst_wr;
  logic              bst_bank;
  logic [COL_W-1:0]  bst_col;
  logic [COL_W:0]    bst_left;
  logic              beat_v;
  logic              beat_wr;
  logic              beat_bank;
  logic [COL_W-1:0]  beat_col;
  logic [COL_W:0]    next_left;
  logic [DQ_W-1:0]   mem [MEM_D];
  logic [DQ_W-1:0]   rd_pipe [3];
  logic [2:0]        rd_v;
  logic [1:0]        dqm_d1;
  logic [1:0]        dqm_d2;
  logic              push;
  logic              drain_v;
  logic [ENT_W-1:0]  drain_w;

  assign cmd      = cke ? decode({cs_n, ras_n, cas_n, we_n}) : sdr_pkg::SDR_NOP;
  assign bl       = mode[`SDR_BL_LSB +: 3];
  assign cl2      = mode[`SDR_CL_LSB +: 3] == `SDR_CL_2;
  assign start_rd = cmd == sdr_pkg::SDR_RD && open[ba];
  assign start_wr = cmd == sdr_pkg::SDR_WR && open[ba];
  assign init_done = mode_set && ref_cnt == `SDR_REF_NEED;

  // A new column command to an open bank always wins over the running burst.
  always_comb begin
    beat_v    = 1'b0;
    beat_wr   = 1'b0;
    beat_bank = bst_bank;
    beat_col  = bst_col;
    if (start_rd || start_wr) begin
      beat_v    = 1'b1;
      beat_wr   = start_wr;
      beat_bank = ba;
      beat_col  = addr[COL_W-1:0];
    end else if (bst_act && cmd != sdr_pkg::SDR_BST) begin
      beat_v  = 1'b1;
      beat_wr = bst_wr;
    end
  end

  always_comb begin
    next_left = bst_left - 1'b1;
    if (start_rd || start_wr) begin
      next_left = (COL_W + 1)'(1) << (bl == `SDR_BL_FULL ? 4'(COL_W) : {1'b0, bl});
      next_left = next_left - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode     <= `SDR_MODE_RST;
      mode_set <= 1'b0;
      ref_cnt  <= '0;
    end else begin
      if (cmd == sdr_pkg::SDR_MRS && open == 2'b00) begin
        mode     <= addr;
        mode_set <= 1'b1;
      end
      if (cmd == sdr_pkg::SDR_REF && ref_cnt != `SDR_REF_NEED) begin
        ref_cnt <= ref_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      open   <= 2'b00;
      row[0] <= '0;
      row[1] <= '0;
    end else if (cmd == sdr_pkg::SDR_ACT) begin
      open[ba] <= 1'b1;
      row[ba]  <= addr;
    end else if (cmd == sdr_pkg::SDR_PRE) begin
      if (addr[ROW_W-1]) begin
        open <= 2'b00;
      end else begin
        open[ba] <= 1'b0;
      end
    end
  end

  // Full-page bursts never count out; they end only by another command.
  always_ff @(posedge clock) begin
    if (rst) begin
      bst_act  <= 1'b0;
      bst_wr   <= 1'b0;
      bst_bank <= 1'b0;
      bst_col  <= '0;
      bst_left <= '0;
    end else if (beat_v) begin
      bst_act  <= next_left != '0 || bl == `SDR_BL_FULL;
      bst_wr   <= beat_wr;
      bst_bank <= beat_bank;
      bst_col  <= next_col(beat_col, bl);
      bst_left <= next_left;
    end else begin
      bst_act <= 1'b0;
    end
  end

  // Writes go through the buffer, so a read right behind a write to the
  // same column may see the old word while the buffer is not yet empty.
  assign push = beat_v && beat_wr && dqm != 2'b11;
  sdr_fifo #(
    .W     (ENT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_ready),
    .in_data   ({beat_bank, row[beat_bank], beat_col, dq_in, ~dqm}),
    .out_valid (drain_v),
    .out_ready (!drain_hold),
    .out_data  (drain_w)
  );

  always_ff @(posedge clock) begin
    if (drain_v && !drain_hold) begin
      for (int b = 0; b < 2; b++) begin
        if (drain_w[b]) begin
          mem[drain_w[ENT_W-1:DQ_W+2]][b*8 +: 8] <= drain_w[2+b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    rd_pipe[0] <= mem[{beat_bank, row[beat_bank], beat_col}];
    rd_pipe[1] <= rd_pipe[0];
    rd_pipe[2] <= rd_pipe[1];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_v   <= '0;
      dqm_d1 <= 2'b11;
      dqm_d2 <= 2'b11;
    end else begin
      rd_v   <= {rd_v[1:0], beat_v && !beat_wr};
      dqm_d1 <= dqm;
      dqm_d2 <= dqm_d1;
    end
  end

  assign dq_out = cl2 ? rd_pipe[1] : rd_pipe[2];
  assign dq_oe  = (cl2 ? rd_v[1] : rd_v[2]) ? ~dqm_d2 : 2'b00;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_rd_cl2;
    start_rd && cl2 && dqm == 2'b00 ##1 dqm == 2'b00;
  endsequence

  // A read of eight words followed by a cycle that neither restarts nor stops it.
  sequence s_rd8_run;
    start_rd && bl == `SDR_BL_8 ##1 !(start_rd || start_wr) && cmd != sdr_pkg::SDR_BST;
  endsequence

  a_mode_load: assert property (
    cmd == sdr_pkg::SDR_MRS && open == 2'b00 |=> mode == $past(addr))
    else $error("mode not loaded from address");
  a_read_latency: assert property (
    s_rd_cl2 |=> dq_oe == 2'b11 && dq_out == $past(rd_pipe[0]))
    else $error("read data not driven at latency two");
  a_mask_float: assert property (
    $past(dqm, 2) == 2'b11 |-> dq_oe == 2'b00)
    else $error("masked read byte still driven");
  a_write_first: assert property (
    start_wr && dqm == 2'b00 && fifo_ready |-> push ##1 bst_wr)
    else $error("first write word not taken");
  a_stop_write: assert property (
    bst_act && cmd == sdr_pkg::SDR_BST |=> !bst_act)
    else $error("burst did not stop");
  a_read_restart: assert property (
    s_rd8_run |-> bst_act && bst_left == 9'h007 ##1 bst_left == 9'h006)
    else $error("interrupting read not a full burst");
  a_seq_wrap: assert property (
    bst_act && beat_v && !(start_rd || start_wr) && bl == `SDR_BL_4
      |=> bst_col[COL_W-1:2] == $past(bst_col[COL_W-1:2]))
    else $error("burst carried out of its block");
  a_write_by_read: assert property (
    bst_act && bst_wr && start_rd |-> !push ##1 !bst_wr)
    else $error("read did not end the write burst");
  a_back_to_back: assert property (
    start_rd ##1 start_rd |-> beat_v && !beat_wr ##1 rd_v[1:0] == 2'b11)
    else $error("back to back reads not accepted");
endmodule : sdr_device

// >>> sdr_ctl_model.sv
// Controller model that drives commands, masks and write data into the DRAM device.
`timescale 1ns/10ps
module sdr_ctl_model #(
  parameter int PAUSE = 20000  // Power-up pause in 10 ns cycles.
) (
  input  wire logic   clock,  // System clock.
  output logic        cke,    // Clock enable.
  output logic        cs_n,   // Chip select.
  output logic        ras_n,  // Row strobe.
  output logic        cas_n,  // Column strobe.
  output logic        we_n,   // Write enable.
  output logic        ba,     // Bank select.
  output logic [10:0] addr,   // Address.
  output logic [1:0]  dqm,    // Byte masks.
  output logic [15:0] dq      // Write data.
);
  localparam logic [2:0] ENC [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h0, 3'h1, 3'h2, 3'h6};
  initial begin
    cke = 1'b1;
    dqm = 2'h3;
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 1'b0;
    addr = 11'h000;
    dq = 16'h0000;
  end
  // A released data bus shows the inverse of its last value, so stale data never matches.
  task automatic cmd(input sdr_pkg::sdr_cmd_t c, input logic b, input logic [10:0] a,
                     input logic [15:0] d, input logic [1:0] m, input logic dv);
    @(posedge clock);
    #1;
    cs_n = 1'b0;
    cke = 1'b1;
    {ras_n, cas_n, we_n} = ENC[c];
    ba = b;
    addr = a;
    dqm = m;
    dq = dv ? d : ~dq;
  endtask : cmd
  // Drives a command with chip select and clock enable chosen, so a dropped command can be shown.
  task automatic gated(input sdr_pkg::sdr_cmd_t c, input logic b, input logic [10:0] a,
                       input logic sel_n, input logic en);
    @(posedge clock);
    #1;
    cs_n = sel_n;
    cke = en;
    {ras_n, cas_n, we_n} = ENC[c];
    ba = b;
    addr = a;
    dqm = 2'h0;
  endtask : gated
  task automatic nop(input int n);
    repeat (n) cmd(sdr_pkg::SDR_NOP, 1'b0, 11'h000, 16'h0000, 2'h0, 1'b0);
  endtask : nop
  task automatic init(input logic [10:0] mode);
    repeat (PAUSE) cmd(sdr_pkg::SDR_NOP, 1'b0, 11'h000, 16'h0000, 2'h3, 1'b0);
    cmd(sdr_pkg::SDR_PRE, 1'b0, 11'h400, 16'h0000, 2'h0, 1'b0);
    repeat (8) begin
      nop(8);
      cmd(sdr_pkg::SDR_REF, 1'b0, 11'h000, 16'h0000, 2'h0, 1'b0);
    end
    nop(8);
    cmd(sdr_pkg::SDR_MRS, 1'b0, mode, 16'h0000, 2'h0, 1'b0);
    nop(2);
  endtask : init
endmodule : sdr_ctl_model

// >>> tb_top.sv
// Self-checking bench: controller model, DRAM device and burst scenarios.
`timescale 1ns/10ps
module tb_top;
  logic        clock, rst, drain_hold, fifo_ready, init_done;
  logic        cke, cs_n, ras_n, cas_n, we_n, ba;
  logic [10:0] addr;
  logic [1:0]  dqm, dq_oe;
  logic [15:0] dq_in, dq_out;
  logic [7:0]  tag;
  logic        bank;
  int          fail_count, n_tests;
  sdr_ctl_model ctl (.clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq(dq_in));
  sdr_device uut (.clock(clock), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .drain_hold(drain_hold), .fifo_ready(fifo_ready),
    .init_done(init_done));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] nxt(input logic [7:0] c, input logic [7:0] m);
    return (c & ~m) | ((c + 8'h01) & m);
  endfunction : nxt
  task automatic wr(input logic [7:0] col, input logic [7:0] m, input int n, input bit stop);
    logic [7:0] c;
    c = col;
    ctl.cmd(sdr_pkg::SDR_WR, bank, {3'h0, c}, {tag, c}, 2'h0, 1'b1);
    for (int i = 1; i < n; i++) begin
      c = nxt(c, m);
      ctl.cmd(sdr_pkg::SDR_NOP, 1'b0, 11'h000, {tag, c}, 2'h0, 1'b1);
    end
    // A beat past the burst would overwrite the start column if it were taken.
    ctl.cmd(stop ? sdr_pkg::SDR_BST : sdr_pkg::SDR_NOP, 1'b0, 11'h000, 16'hFFFF, 2'h0, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] col, input logic [7:0] m, input int cl, input int n,
                    input logic [1:0] mk, input int st);
    logic [7:0]  c;
    logic [1:0]  e;
    logic [15:0] k;
    c = col;
    // The mask acts two edges on, so at latency three it rides on the cycle after the read.
    ctl.cmd(sdr_pkg::SDR_RD, bank, {3'h0, col}, 16'h0000, (cl == 2) ? mk : 2'h0, 1'b0);
    if (cl == 3) begin
      ctl.cmd(sdr_pkg::SDR_NOP, 1'b0, 11'h000, 16'h0000, mk, 1'b0);
    end
    ctl.nop(1);
    for (int i = 0; i < n; i++) begin
      ctl.cmd((i == st) ? sdr_pkg::SDR_BST : sdr_pkg::SDR_NOP, 1'b0, 11'h000, 16'h0000, 2'h0,
              1'b0);
      e = (i == 0) ? ~mk : 2'h3;
      k = {{8{e[1]}}, {8{e[0]}}};
      chk("read data", {tag, c} & k, dq_out & k);
      chk("drive enable", {14'h0, e}, {14'h0, dq_oe});
      c = nxt(c, m);
    end
    ctl.nop(1);
    chk("release", 16'h0000, {14'h0, dq_oe});
  endtask : rd
  task automatic setup(input logic [10:0] mode);
    ctl.cmd(sdr_pkg::SDR_PRE, 1'b0, 11'h400, 16'h0000, 2'h0, 1'b0);
    ctl.nop(2);
    ctl.cmd(sdr_pkg::SDR_MRS, 1'b0, mode, 16'h0000, 2'h0, 1'b0);
    ctl.nop(2);
    ctl.cmd(sdr_pkg::SDR_ACT, 1'b0, 11'h155, 16'h0000, 2'h0, 1'b0);
    ctl.nop(3);
  endtask : setup
  task automatic s_modes();
    logic [7:0] m;
    for (int cl = 2; cl <= 3; cl++) begin
      for (int b = 0; b < 4; b++) begin
        tag = 8'(16 * cl + b);
        m = 8'((1 << b) - 1);
        setup({4'h0, 3'(cl), 1'b0, 3'(b)});
        wr(8'h3D, m, 1 << b, 1'b0);
        ctl.nop(4);
        rd(nxt(8'h3D, m), m, cl, 1 << b, 2'h0, 99);
      end
    end
  endtask : s_modes
  task automatic s_interrupt();
    ctl.cmd(sdr_pkg::SDR_RD, 1'b0, 11'h038, 16'h0000, 2'h0, 1'b0);
    rd(8'h3C, 8'h07, 3, 8, 2'h0, 99);
    rd(8'h3A, 8'h07, 3, 8, 2'h1, 99);
  endtask : s_interrupt
  task automatic s_banks();
    tag = 8'h5A;
    setup(11'h022);
    ctl.cmd(sdr_pkg::SDR_ACT, 1'b1, 11'h2AA, 16'h0000, 2'h0, 1'b0);
    ctl.nop(3);
    bank = 1'b1;
    ctl.gated(sdr_pkg::SDR_RD, 1'b1, 11'h010, 1'b1, 1'b1);
    ctl.gated(sdr_pkg::SDR_RD, 1'b1, 11'h010, 1'b0, 1'b0);
    ctl.nop(1);
    chk("deselected read", 16'h0000, {14'h0, dq_oe});
    ctl.nop(1);
    chk("clock disabled read", 16'h0000, {14'h0, dq_oe});
    // The first burst is overwritten by a second one that must run its full length.
    ctl.cmd(sdr_pkg::SDR_WR, 1'b1, 11'h012, 16'hA512, 2'h0, 1'b1);
    ctl.cmd(sdr_pkg::SDR_NOP, 1'b1, 11'h000, 16'hA513, 2'h0, 1'b1);
    wr(8'h10, 8'h03, 4, 1'b0);
    // The read cuts this write after one word, so column 10 must keep its data.
    ctl.cmd(sdr_pkg::SDR_WR, 1'b1, 11'h013, {tag, 8'h13}, 2'h0, 1'b1);
    rd(8'h10, 8'h03, 2, 4, 2'h0, 99);
    rd(8'h10, 8'h03, 2, 4, 2'h0, 99);
    ctl.cmd(sdr_pkg::SDR_RD, 1'b1, 11'h018, 16'h0000, 2'h3, 1'b0);
    ctl.cmd(sdr_pkg::SDR_NOP, 1'b1, 11'h000, 16'h0000, 2'h3, 1'b0);
    ctl.cmd(sdr_pkg::SDR_WR, 1'b1, 11'h01C, {tag, 8'h1C}, 2'h0, 1'b1);
    chk("masked first read word", 16'h0000, {14'h0, dq_oe});
    ctl.cmd(sdr_pkg::SDR_NOP, 1'b1, 11'h000, {tag, 8'h1D}, 2'h0, 1'b1);
    chk("masked second read word", 16'h0000, {14'h0, dq_oe});
    ctl.cmd(sdr_pkg::SDR_NOP, 1'b1, 11'h000, {tag, 8'h1E}, 2'h0, 1'b1);
    chk("write owns bus", 16'h0000, {14'h0, dq_oe});
    ctl.cmd(sdr_pkg::SDR_NOP, 1'b1, 11'h000, {tag, 8'h1F}, 2'h0, 1'b1);
    rd(8'h1C, 8'h03, 2, 4, 2'h0, 99);
    bank = 1'b0;
  endtask : s_banks
  task automatic s_full_page();
    tag = 8'h77;
    setup(11'h027);
    wr(8'hFE, 8'hFF, 3, 1'b1);
    ctl.nop(4);
    rd(8'hFE, 8'hFF, 2, 3, 2'h0, 1);
  endtask : s_full_page
  task automatic s_buffer();
    int w;
    drain_hold = 1'b1;
    wr(8'h00, 8'hFF, 34, 1'b1);
    chk("buffer full", 16'h0000, {15'h0, fifo_ready});
    drain_hold = 1'b0;
    w = 0;
    while (fifo_ready !== 1'b1 && w < 100) begin
      ctl.nop(1);
      w++;
    end
    if (w >= 100) begin
      fail_count++;
      $display("mismatch buffer drain expected 1 seen %b", fifo_ready);
      end_of_test();
    end
  endtask : s_buffer
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    rst = 1'b1;
    drain_hold = 1'b0;
    tag = 8'h00;
    bank = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (16) @(posedge clock);
    #1;
    rst = 1'b0;
    chk("reset state", 16'h0001, {12'h0, dq_oe, init_done, fifo_ready});
    ctl.init(11'h022);
    chk("init done", 16'h0001, {15'h0, init_done});
    s_modes();
    s_interrupt();
    s_banks();
    s_full_page();
    s_buffer();
    end_of_test();
  end
endmodule : tb_top
